// [programmable_macrocell_array.sv]
// Eight configurable output macrocells fed by a shared AND array
//
// Functional notes
// [RULE1] Registered: special pins are clock and enable
// [RULE2] Complex: special pins enter via outer feedback
// [RULE3] Complex: outer cells lose their pin feedback
// [RULE4] Simple: pin feedback uses the neighbour's path
// [RULE5] Simple: centre cells are fixed outputs
// [RULE6] Registered: each cell register or bidirectional
// [RULE7] Registered cells share clock and enable pins
// [RULE8] Any register/bidirectional mixture is allowed
// [RULE9] Register sums eight terms; bidirectional seven
// [RULE10] Complex: output-only or bidirectional, polarity
// [RULE11] Complex: at most six bidirectional cells
// [RULE12] Complex: seven terms plus enable term
// [RULE13] Complex and simple: special pins are inputs
// [RULE14] Simple: dedicated input or always-on output
// [RULE15] Simple: eight terms, programmable polarity
// [RULE16] Tool picks mode from register and enable use
// [RULE17] Two global bits select the mode
// [RULE18] Per-cell polarity bit in every mode
// [RULE19] Per-cell bit picks configuration within mode
// [RULE20] Registers load on clock pin rise, gated drive
// [RULE21] Each product term can be disabled
`timescale 1ns/100ps
`default_nettype none
module programmable_macrocell_array
	import pld_pkg::*;
#(
	parameter int CELLS = NUM_CELLS,
	parameter int INPUTS = NUM_INPUTS,
	parameter int TERMS = TERMS_PER_CELL
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic [INPUTS-1:0] i_in,
	input wire logic i_glob_clk_or_in,
	input wire logic i_glob_oe_n_or_in,
	input wire logic [CELLS-1:0] i_cell_pin,
	output logic [CELLS-1:0] o_cell_pin,
	output logic [CELLS-1:0] o_cell_oe
);

	localparam int COLS = 2 * (INPUTS + CELLS);
	localparam int NT = CELLS * TERMS;
	localparam int IW = $clog2(NT);
	localparam int CL = CELLS / 2 - 1;
	localparam int CR = CELLS / 2;

	if (CELLS < 4 || CELLS > 8 || CELLS % 2 != 0 || INPUTS < 1 || TERMS < 2 ||
		COLS > 32 || NT > 64) begin : g_bad_size
		$error("unsupported array size");
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Unconnected term reads true unless disabled
	function automatic logic term_eval(input logic [COLS-1:0] conn,
		input logic [COLS-1:0] cols, input logic dis);
		return !dis && (&(~conn | cols));
	endfunction : term_eval

	function automatic logic addr_is(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] off);
		return a[ADDR_W-1:2] == off[ADDR_W-1:2];
	endfunction : addr_is

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	mode_type mode;
	logic [CELLS-1:0] io_cfg;
	logic [CELLS-1:0] pol;
	logic [31:0] term_dis_lo;
	logic [31:0] term_dis_hi;
	logic [31:0] signature;
	logic [CELLS-1:0] reg_q;
	logic clk_prev;
	logic rd_pend;
	logic [31:0] rd_word;

	logic [NT-1:0] term_dis;
	logic [CELLS-1:0] fb;
	logic [COLS-1:0] cols;
	logic [NT-1:0] term;
	logic [CELLS-1:0] sum_all;
	logic [CELLS-1:0] sum_rest;
	logic [CELLS-1:0] pt_oe;
	logic [CELLS-1:0] next_pin;
	logic [CELLS-1:0] next_oe;
	logic [CELLS-1:0] next_q;
	logic [CELLS-1:0] centre;
	logic clk_rise;

	fuse_if #(.WORDS(NT), .WIDTH(COLS)) fuse ();

	fuse_store #(.WORDS(NT), .WIDTH(COLS)) u_fuse (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.bus(fuse.store)
	);

	assign term_dis = NT'({term_dis_hi, term_dis_lo});
	assign centre = CELLS'((1 << CL) | (1 << CR));
	assign clk_rise = i_glob_clk_or_in & ~clk_prev;

	// ----------------------------------------------------------------
	// Feedback routing into the array
	// ----------------------------------------------------------------
	always_comb begin
		fb = '0;
		case (mode)
			MODE_REGISTERED: begin
				// Special pins never reach the array here [RULE1]
				for (int i = 0; i < CELLS; i++) begin
					fb[i] = io_cfg[i] ? i_cell_pin[i] : reg_q[i]; // [RULE6]
				end
			end
			MODE_COMPLEX: begin
				for (int i = 1; i < CELLS - 1; i++) begin
					fb[i] = io_cfg[i] ? i_cell_pin[i] : 1'b0; // [RULE10] [RULE11]
				end
				fb[0] = i_glob_clk_or_in; // [RULE2] [RULE3] [RULE13]
				fb[CELLS-1] = i_glob_oe_n_or_in; // [RULE2] [RULE3] [RULE13]
			end
			default: begin
				// Reserved code behaves as simple mode
				for (int i = 0; i < CL; i++) begin
					fb[i+1] = i_cell_pin[i]; // [RULE4]
				end
				for (int i = CR + 1; i < CELLS; i++) begin
					fb[i-1] = i_cell_pin[i]; // [RULE4]
				end
				fb[0] = i_glob_clk_or_in; // [RULE13]
				fb[CELLS-1] = i_glob_oe_n_or_in; // [RULE13]
			end
		endcase
	end

	assign cols = {~{fb, i_in}, {fb, i_in}};

	// ----------------------------------------------------------------
	// Product terms and sums
	// ----------------------------------------------------------------
	always_comb begin
		for (int k = 0; k < NT; k++) begin
			term[k] = term_eval(fuse.words[k], cols, term_dis[k]); // [RULE21]
		end
		for (int i = 0; i < CELLS; i++) begin
			sum_all[i] = |term[i*TERMS +: TERMS]; // [RULE9] [RULE15]
			sum_rest[i] = |term[i*TERMS+1 +: TERMS-1]; // [RULE9] [RULE12]
			pt_oe[i] = term[i*TERMS];
		end
	end

	// ----------------------------------------------------------------
	// Macrocell output selection
	// ----------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < CELLS; i++) begin
			next_q[i] = sum_all[i] ^ pol[i]; // [RULE9] [RULE18]
			case (mode)
				MODE_REGISTERED: begin
					if (!io_cfg[i]) begin
						next_pin[i] = reg_q[i];
						next_oe[i] = !i_glob_oe_n_or_in; // [RULE7] [RULE20]
					end else begin
						next_pin[i] = sum_rest[i] ^ pol[i]; // [RULE6] [RULE8]
						next_oe[i] = pt_oe[i]; // [RULE9]
					end
				end
				MODE_COMPLEX: begin
					next_pin[i] = sum_rest[i] ^ pol[i]; // [RULE10] [RULE18]
					next_oe[i] = pt_oe[i]; // [RULE12]
				end
				default: begin
					next_pin[i] = sum_all[i] ^ pol[i]; // [RULE15] [RULE18]
					next_oe[i] = !io_cfg[i] || centre[i]; // [RULE5] [RULE14]
				end
			endcase
		end
	end

	// Clock pin is sampled, so it must stay below half the system clock
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			clk_prev <= 1'b0;
		end else begin
			clk_prev <= i_glob_clk_or_in;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			reg_q <= '0;
		end else if (mode == MODE_REGISTERED && clk_rise) begin
			reg_q <= next_q; // [RULE7] [RULE20]
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_cell_pin <= '0;
			o_cell_oe <= '0;
		end else begin
			o_cell_pin <= next_pin;
			o_cell_oe <= next_oe;
		end
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	logic acc;
	logic is_fuse;
	logic hit;
	logic wr;
	logic [31:0] csr_rd;

	assign acc = i_psel & i_penable;
	assign is_fuse = i_paddr[ADDR_W-1:FUSE_PAGE_LSB] == ADDR_FUSE_BASE[ADDR_W-1:FUSE_PAGE_LSB]
		&& 32'(i_paddr[FUSE_PAGE_LSB-1:FUSE_IDX_LSB]) < NT;
	assign o_pready = acc & (i_pwrite | rd_pend);
	assign o_pslverr = o_pready & ~hit;
	assign wr = acc & i_pwrite & hit;
	assign o_prdata = rd_word;

	// Reads take two access cycles so fuse words come out of a register
	assign fuse.rd_en = i_psel & ~i_penable;
	assign fuse.rd_idx = IW'(i_paddr[FUSE_IDX_LSB +: IW]);
	assign fuse.wr_en = wr & is_fuse;
	assign fuse.wr_idx = IW'(i_paddr[FUSE_IDX_LSB +: IW]);
	assign fuse.wr_data = i_pwdata[COLS-1:0];

	always_comb begin
		hit = 1'b1;
		csr_rd = '0;
		if (is_fuse) begin
			csr_rd = 32'(fuse.rd_data);
		end else if (addr_is(i_paddr, ADDR_CTRL)) begin
			csr_rd[CTRL_SYNC_BIT] = mode[1];
			csr_rd[CTRL_ARCH_BIT] = mode[0];
		end else if (addr_is(i_paddr, ADDR_CELL_CFG)) begin
			csr_rd[CFG_IO_LSB +: CELLS] = io_cfg;
			csr_rd[CFG_POL_LSB +: CELLS] = pol;
		end else if (addr_is(i_paddr, ADDR_TERM_DIS_LO)) begin
			csr_rd = term_dis_lo;
		end else if (addr_is(i_paddr, ADDR_TERM_DIS_HI)) begin
			csr_rd = term_dis_hi;
		end else if (addr_is(i_paddr, ADDR_STATUS)) begin
			csr_rd[STAT_PIN_LSB +: CELLS] = o_cell_pin;
			csr_rd[STAT_OE_LSB +: CELLS] = o_cell_oe;
			csr_rd[STAT_REG_LSB +: CELLS] = reg_q;
			csr_rd[STAT_MODE_LSB +: 2] = mode;
		end else if (addr_is(i_paddr, ADDR_PIN_IN)) begin
			csr_rd[PIN_IN_DED_LSB +: INPUTS] = i_in;
			csr_rd[PIN_IN_CELL_LSB +: CELLS] = i_cell_pin;
			csr_rd[PIN_IN_CLK_BIT] = i_glob_clk_or_in;
			csr_rd[PIN_IN_OE_BIT] = i_glob_oe_n_or_in;
		end else if (addr_is(i_paddr, ADDR_SIGNATURE)) begin
			csr_rd = signature;
		end else begin
			hit = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rd_pend <= 1'b0;
			rd_word <= '0;
		end else if (acc && !i_pwrite && !rd_pend) begin
			rd_pend <= 1'b1;
			rd_word <= csr_rd;
		end else begin
			rd_pend <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			mode <= CTRL_RESET;
		end else if (wr && addr_is(i_paddr, ADDR_CTRL)) begin
			mode <= mode_type'({i_pwdata[CTRL_SYNC_BIT], i_pwdata[CTRL_ARCH_BIT]}); // [RULE17]
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			io_cfg <= IO_CFG_RESET[CELLS-1:0];
			pol <= POL_RESET[CELLS-1:0];
		end else if (wr && addr_is(i_paddr, ADDR_CELL_CFG)) begin
			io_cfg <= i_pwdata[CFG_IO_LSB +: CELLS]; // [RULE19]
			pol <= i_pwdata[CFG_POL_LSB +: CELLS]; // [RULE18]
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			term_dis_lo <= TERM_DIS_RESET;
			term_dis_hi <= TERM_DIS_RESET;
			signature <= SIGNATURE_RESET;
		end else if (wr) begin
			if (addr_is(i_paddr, ADDR_TERM_DIS_LO)) begin
				term_dis_lo <= i_pwdata; // [RULE21]
			end
			if (addr_is(i_paddr, ADDR_TERM_DIS_HI)) begin
				term_dis_hi <= i_pwdata; // [RULE21]
			end
			if (addr_is(i_paddr, ADDR_SIGNATURE)) begin
				signature <= i_pwdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_reg_hold;
		@(posedge i_clk) disable iff (i_rst)
		// Sampled reset in the antecedent: the release edge still shows reset values
		!i_rst && !(mode == MODE_REGISTERED && clk_rise) |=> reg_q == $past(reg_q);
	endproperty
	a_reg_hold: assert property (p_reg_hold) else $error("register moved without clock rise"); // [RULE20]

	property p_reg_oe;
		@(posedge i_clk) disable iff (i_rst)
		(!i_rst && mode == MODE_REGISTERED && io_cfg[0] == 1'b0) |=>
			o_cell_oe[0] == !$past(i_glob_oe_n_or_in) && o_cell_pin[0] == $past(reg_q[0]);
	endproperty
	a_reg_oe: assert property (p_reg_oe) else $error("register cell drive not from common pins"); // [RULE7]

	property p_simple_oe;
		@(posedge i_clk) disable iff (i_rst)
		!i_rst && mode == MODE_SIMPLE |=> o_cell_oe == ($past(~io_cfg) | centre);
	endproperty
	a_simple_oe: assert property (p_simple_oe) else $error("simple mode enable wrong"); // [RULE14]

	property p_centre_out;
		@(posedge i_clk) disable iff (i_rst)
		!i_rst && mode == MODE_SIMPLE ##1 mode == MODE_SIMPLE |-> o_cell_oe[CL] && o_cell_oe[CR];
	endproperty
	a_centre_out: assert property (p_centre_out) else $error("centre cell not driving"); // [RULE5]

	property p_complex_fb;
		@(posedge i_clk) disable iff (i_rst)
		mode == MODE_COMPLEX |-> fb[0] == i_glob_clk_or_in && fb[CELLS-1] == i_glob_oe_n_or_in;
	endproperty
	a_complex_fb: assert property (p_complex_fb) else $error("special pins not on outer paths"); // [RULE2]

	property p_complex_io;
		@(posedge i_clk) disable iff (i_rst)
		mode == MODE_COMPLEX |-> fb[CELLS-2:1] == (io_cfg[CELLS-2:1] & i_cell_pin[CELLS-2:1]);
	endproperty
	a_complex_io: assert property (p_complex_io) else $error("inner feedback not from io pins"); // [RULE11]

	property p_simple_route;
		@(posedge i_clk) disable iff (i_rst)
		mode == MODE_SIMPLE |-> fb[1] == i_cell_pin[0] && fb[CELLS-2] == i_cell_pin[CELLS-1];
	endproperty
	a_simple_route: assert property (p_simple_route) else $error("neighbour routing wrong"); // [RULE4]

	property p_term_dis;
		@(posedge i_clk) disable iff (i_rst)
		(term & term_dis) == '0;
	endproperty
	a_term_dis: assert property (p_term_dis) else $error("disabled term active"); // [RULE21]

	property p_mode_write;
		@(posedge i_clk) disable iff (i_rst)
		wr && addr_is(i_paddr, ADDR_CTRL) |=>
			mode == {$past(i_pwdata[CTRL_SYNC_BIT]), $past(i_pwdata[CTRL_ARCH_BIT])};
	endproperty
	a_mode_write: assert property (p_mode_write) else $error("mode bits not taken"); // [RULE17]

endmodule : programmable_macrocell_array
`default_nettype wire

// [pld_pkg.sv]
// Shared constants, register map and mode encoding for the macrocell array
package pld_pkg;

	// ----------------------------------------------------------------
	// Array sizes
	// ----------------------------------------------------------------
	localparam int NUM_CELLS = 8;
	localparam int NUM_INPUTS = 8;
	localparam int TERMS_PER_CELL = 8;
	localparam int ADDR_W = 12;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_CELL_CFG = 12'h004;
	localparam logic [11:0] ADDR_TERM_DIS_LO = 12'h008;
	localparam logic [11:0] ADDR_TERM_DIS_HI = 12'h00c;
	localparam logic [11:0] ADDR_STATUS = 12'h010;
	localparam logic [11:0] ADDR_PIN_IN = 12'h014;
	localparam logic [11:0] ADDR_SIGNATURE = 12'h018;
	localparam logic [11:0] ADDR_FUSE_BASE = 12'h100;
	localparam int FUSE_PAGE_LSB = 8;
	localparam int FUSE_IDX_LSB = 2;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_ARCH_BIT = 0;
	localparam int CTRL_SYNC_BIT = 1;
	localparam int CFG_IO_LSB = 0;
	localparam int CFG_POL_LSB = 8;
	localparam int STAT_PIN_LSB = 0;
	localparam int STAT_OE_LSB = 8;
	localparam int STAT_REG_LSB = 16;
	localparam int STAT_MODE_LSB = 24;
	localparam int PIN_IN_DED_LSB = 0;
	localparam int PIN_IN_CELL_LSB = 8;
	localparam int PIN_IN_CLK_BIT = 16;
	localparam int PIN_IN_OE_BIT = 17;

	// ----------------------------------------------------------------
	// Modes: {global_sync_mode_bit, global_arch_mode_bit}
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_RESERVED = 2'b00,
		MODE_REGISTERED = 2'b01,
		MODE_SIMPLE = 2'b10,
		MODE_COMPLEX = 2'b11
	} mode_type;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam mode_type CTRL_RESET = MODE_SIMPLE;
	localparam logic [7:0] IO_CFG_RESET = 8'h00;
	localparam logic [7:0] POL_RESET = 8'h00;
	localparam logic [31:0] TERM_DIS_RESET = 32'hffffffff;
	// Arbitrary neutral value
	localparam logic [31:0] SIGNATURE_RESET = 32'h00000000;

endpackage : pld_pkg

// [fuse_if.sv]
// Port bundle between the register logic and the term fuse store
`timescale 1ns/100ps
`default_nettype none
interface fuse_if #(
	parameter int WORDS = 64,
	parameter int WIDTH = 32
);
	logic wr_en;
	logic [$clog2(WORDS)-1:0] wr_idx;
	logic [WIDTH-1:0] wr_data;
	logic rd_en;
	logic [$clog2(WORDS)-1:0] rd_idx;
	logic [WIDTH-1:0] rd_data;
	logic [WORDS-1:0][WIDTH-1:0] words;

	modport store (
		input wr_en, wr_idx, wr_data, rd_en, rd_idx,
		output rd_data, words
	);
	modport user (
		output wr_en, wr_idx, wr_data, rd_en, rd_idx,
		input rd_data, words
	);
endinterface : fuse_if
`default_nettype wire

// [fuse_store.sv]
// Connection fuse words of every product term, with registered read port
`timescale 1ns/100ps
`default_nettype none
module fuse_store #(
	parameter int WORDS = 64,
	parameter int WIDTH = 32
) (
	input wire logic i_clk,
	input wire logic i_rst,
	fuse_if.store bus
);

	if (WORDS < 2 || WIDTH < 1) begin : g_bad_size
		$error("unsupported store size");
	end

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	// All words are flops: the array evaluates every term at once
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			bus.words <= '0;
		end else if (bus.wr_en) begin
			bus.words[bus.wr_idx] <= bus.wr_data;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			bus.rd_data <= '0;
		end else if (bus.rd_en) begin
			bus.rd_data <= bus.words[bus.rd_idx];
		end
	end

endmodule : fuse_store
`default_nettype wire

// [board_model.sv]
// Board-side model that resolves the shared macrocell pin wires
`timescale 1ns/100ps
`default_nettype none
module board_model (
	input wire logic [7:0] i_drive,
	input wire logic [7:0] i_drive_en,
	input wire logic [7:0] i_ext,
	input wire logic [7:0] i_ext_en,
	output logic [7:0] o_level
);
	// ----------------------------------------------------------------
	// Wire resolution
	// ----------------------------------------------------------------
	// Undriven pins float to the pull-up, never to the last driven value
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (i_drive_en[i]) begin
				o_level[i] = i_drive[i];
			end else if (i_ext_en[i]) begin
				o_level[i] = i_ext[i];
			end else begin
				o_level[i] = 1'b1;
			end
		end
	end
endmodule : board_model
`default_nettype wire

// [programmable_macrocell_array_tb_top.sv]
// Self-checking bench for the macrocell array
`timescale 1ns/100ps
`default_nettype none
module programmable_macrocell_array_tb_top import pld_pkg::*;;
	typedef struct {
		string name;
		logic [31:0] mask;
		logic [31:0] exp;
		logic err;
	} note_type;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic clkpin = 1'b0;
	logic oepin = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [7:0] in_bus = 8'h00;
	logic [7:0] ext_val = 8'h00;
	logic [7:0] ext_en = 8'h00;
	logic [7:0] lfsr = 8'h5f;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] pin_out;
	logic [7:0] pin_oe;
	logic [7:0] pin_lvl;
	note_type notes[$];
	note_type cur;
	int bad_count = 0;
	int checked = 0;
	int cycles = 0;

	initial forever #50 clk = ~clk;

	programmable_macrocell_array DUT (
		.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_in(in_bus), .i_glob_clk_or_in(clkpin),
		.i_glob_oe_n_or_in(oepin), .i_cell_pin(pin_lvl), .o_cell_pin(pin_out),
		.o_cell_oe(pin_oe)
	);
	board_model board (
		.i_drive(pin_out), .i_drive_en(pin_oe), .i_ext(ext_val), .i_ext_en(ext_en),
		.o_level(pin_lvl)
	);
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr_next

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// No cycle limit here: only the bench timeout ends a stuck slave
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge so a following call never reassigns psel in this step
		@(posedge clk);
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		repeat (3) @(posedge clk);
	endtask : wr

	task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] e, input logic er);
		notes.push_back(note_type'{nm, m, e, er});
		apb(1'b0, a, 32'h00000000);
	endtask : rd

	task automatic pulse();
		clkpin <= 1'b0;
		repeat (2) @(posedge clk);
		clkpin <= 1'b1;
		repeat (2) @(posedge clk);
		clkpin <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : pulse

	task automatic end_of_test();
		if (notes.size() != 0) bad_count++;
		if (bad_count == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_of_test
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Read data taken at the rising edge where ready is seen high
	always @(posedge clk) begin
		if (psel && penable && !pwrite && pready === 1'b1) begin
			if (notes.size() == 0) begin
				bad_count++;
				$display("[FAIL] read expected none seen %h", prdata);
			end else begin
				cur = notes.pop_front();
				checked++;
				if (((prdata & cur.mask) !== cur.exp) || (pslverr !== cur.err)) begin
					bad_count++;
					$display("[FAIL] %s expected %h err %b seen %h err %b",
						cur.name, cur.exp, cur.err, prdata & cur.mask, pslverr);
				end
			end
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			end_of_test();
		end
	end
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd("ctrl", ADDR_CTRL, 32'hffffffff, 32'h00000002, 1'b0);
		rd("term_lo", ADDR_TERM_DIS_LO, 32'hffffffff, 32'hffffffff, 1'b0);
		rd("cfg", ADDR_CELL_CFG, 32'hffffffff, 32'h00000000, 1'b0);
		rd("status", ADDR_STATUS, 32'h0300ffff, 32'h0200ff00, 1'b0);
		rd("unmapped", 12'h01c, 32'hffffffff, 32'h00000000, 1'b1);
		for (int i = 0; i < 4; i++) begin
			lfsr = lfsr_next(lfsr);
			in_bus <= lfsr;
			wr(ADDR_SIGNATURE, {4{lfsr}});
			rd("signature", ADDR_SIGNATURE, 32'hffffffff, {4{lfsr}}, 1'b0);
			rd("pin_in", ADDR_PIN_IN, 32'h000000ff, {24'h000000, lfsr}, 1'b0);
		end
		wr(ADDR_CELL_CFG, 32'h0000ff00);
		rd("polarity", ADDR_STATUS, 32'h0000ffff, 32'h0000ffff, 1'b0);
		wr(ADDR_CELL_CFG, 32'h000000ff);
		rd("inputs", ADDR_STATUS, 32'h0000ff00, 32'h00001800, 1'b0);
		// Cell 0 becomes an input so the board can steer its feedback
		wr(ADDR_CELL_CFG, 32'h00000001);
		ext_en <= 8'h01;
		wr(ADDR_FUSE_BASE + 12'h020, 32'h00000200);
		wr(ADDR_FUSE_BASE + 12'h040, 32'h00000100);
		wr(ADDR_FUSE_BASE + 12'h060, 32'h00008000);
		wr(ADDR_TERM_DIS_LO, 32'hfefefeff);
		for (int i = 0; i < 8; i++) begin
			ext_val[0] <= i[0];
			clkpin <= i[1];
			oepin <= i[2];
			repeat (4) @(posedge clk);
			rd("simple", ADDR_STATUS, 32'h0000ffff, {16'h0000, 8'hfe, 4'h0, i[2:0], 1'b0},
				1'b0);
		end
		ext_en <= 8'h80;
		wr(ADDR_CTRL, 32'h00000003);
		wr(ADDR_CELL_CFG, 32'h00000c80);
		for (int i = 0; i < 4; i++) begin
			clkpin <= i[0];
			oepin <= i[1];
			ext_val[7] <= ~i[1];
			repeat (4) @(posedge clk);
			rd("complex", ADDR_STATUS, 32'h0000ffff, {20'h00000, i[1:0], 10'h00c},
				1'b0);
		end
		clkpin <= 1'b0;
		oepin <= 1'b0;
		ext_en <= 8'h00;
		wr(ADDR_FUSE_BASE + 12'h020, 32'h00000000);
		wr(ADDR_CTRL, 32'h00000001);
		rd("ctrl", ADDR_CTRL, 32'hffffffff, 32'h00000001, 1'b0);
		wr(ADDR_CELL_CFG, 32'h00000002);
		wr(ADDR_TERM_DIS_LO, 32'hfffffcfd);
		pulse();
		rd("registered", ADDR_STATUS, 32'h00fdffff, 32'h0001ff03, 1'b0);
		oepin <= 1'b1;
		wr(ADDR_TERM_DIS_LO, 32'hffffffff);
		rd("held", ADDR_STATUS, 32'h00fdffff, 32'h00010001, 1'b0);
		pulse();
		rd("cleared", ADDR_STATUS, 32'h00fdffff, 32'h00000000, 1'b0);
		// Reserved code reads back as written and drives like simple mode
		wr(ADDR_CTRL, 32'h00000000);
		rd("reserved", ADDR_CTRL, 32'hffffffff, 32'h00000000, 1'b0);
		rd("reserved_pins", ADDR_STATUS, 32'h03ffffff, 32'h0000fd00, 1'b0);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd("ctrl_again", ADDR_CTRL, 32'hffffffff, 32'h00000002, 1'b0);
		rd("status_again", ADDR_STATUS, 32'h03ffffff, 32'h0200ff00, 1'b0);
		end_of_test();
	end
endmodule : programmable_macrocell_array_tb_top
`default_nettype wire
